// >>> core/pdh_pkg.sv
// Purpose: Constants for the palette DAC host port
// Assumes: 8-bit host data bus, 40 MHz system clock
// Notes: Control register indices live in the index pointer space
package pdh_pkg;
  localparam int DATA_W = 8;
  localparam logic [1:0] SEL_POINTER = 2'h0;
  localparam logic [1:0] SEL_PALETTE = 2'h1;
  localparam logic [1:0] SEL_CONTROL = 2'h2;
  localparam logic [1:0] SEL_OVERLAY = 2'h3;
  localparam logic [7:0] IDX_READ_MASK = 8'h04;
  localparam logic [7:0] IDX_BLINK_MASK = 8'h05;
  localparam logic [7:0] IDX_CONFIG = 8'h06;
  localparam logic [7:0] IDX_DIAG = 8'h07;
  localparam logic [7:0] RST_READ_MASK = 8'hff;
  localparam logic [7:0] RST_BLINK_MASK = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h40;
  localparam logic [7:0] RST_DIAG = 8'h00;
  localparam logic [7:0] RST_POINTER = 8'h00;
  localparam logic [1:0] COMP_RED = 2'h0;
  localparam logic [1:0] COMP_GREEN = 2'h1;
  localparam logic [1:0] COMP_BLUE = 2'h2;
  localparam int CFG_MUX4_BIT = 6;
  localparam int CFG_OVL_EN_BIT = 0;
  typedef enum logic [1:0] {
    PDH_IDLE = 2'b00,
    PDH_ACTIVE = 2'b01
  } pdh_state_t;
endpackage

// >>> core/pdh_host_port.sv
// Purpose: Host processor port of a palette DAC: pointer, control registers, palettes
// Assumes: Host pins are asynchronous to CLK_I and are synchronised here
// Notes: Host accesses are framed by the chip-enable strobe (active low)
//
// Function
// - Select 0,0 addresses the index pointer; a write loads it from the bus.
// - Select 1,0 addresses the control register chosen by the pointer; a write stores to it.
// - The device configuration register sits at pointer index 06H.
// - Configuration value 40H means 4:1 multiplexing, palette on, 16/48 blink, no blink, overlay forced 0.
// - The pixel read mask sits at index 04H and the host loads it with FFH.
// - The blink mask sits at index 05H and the host loads it with 00H.
// - The diagnostic register sits at index 07H and the host loads it with 00H.
// - A palette entry is written by loading the pointer, then red, green, blue with select 0,1.
// - After the third component the pointer advances by one.
// - Reads use the same sequence with read/write high; the device drives the stored value.
// - Select 1,1 reaches the overlay palette with the same triplet sequence.
// - Overlay entry 0 reads back red, green, blue over three reads after loading pointer 00H.
`timescale 1ns/1ps
`default_nettype none
module pdh_host_port
  import pdh_pkg::*;
#(
  parameter int PAL_DEPTH = 256,
  parameter int OVL_DEPTH = 16
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_N_I,
  input wire logic RD_WR_N_I,
  input wire logic SELECT_HIGH_I,
  input wire logic SELECT_LOW_I,
  input wire logic [7:0] DATA_I,
  output logic [7:0] DATA_O,
  output logic DATA_OE_O,
  output logic [7:0] READ_MASK_O,
  output logic [7:0] BLINK_MASK_O,
  output logic [7:0] CONFIG_O,
  output logic [7:0] DIAG_O,
  output logic [7:0] POINTER_O
);
  // ********************************
  // Pin synchronisers
  // ********************************
  logic [11:0] pins_s1_r;
  logic [11:0] pins_s2_r;
  logic [11:0] pins_nxt;
  always_comb begin
    pins_nxt = {CE_N_I, RD_WR_N_I, SELECT_HIGH_I, SELECT_LOW_I, DATA_I};
  end
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      pins_s1_r <= 12'hc00;
      pins_s2_r <= 12'hc00;
    end else begin
      pins_s1_r <= pins_nxt;
      pins_s2_r <= pins_s1_r;
    end
  end
  logic ce_n_s;
  logic rd_s;
  logic [1:0] sel_s;
  logic [7:0] din_s;
  assign ce_n_s = pins_s2_r[11];
  assign rd_s = pins_s2_r[10];
  assign sel_s = pins_s2_r[9:8];
  assign din_s = pins_s2_r[7:0];

  // ********************************
  // Storage
  // ********************************
  logic [23:0] pal_mem [PAL_DEPTH];
  logic [23:0] ovl_mem [OVL_DEPTH];

  // ********************************
  // Access state
  // ********************************
  pdh_state_t state_r, state_nxt;
  logic rd_r, rd_nxt;
  logic [1:0] sel_r, sel_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic [1:0] comp_r, comp_nxt;
  logic [7:0] red_r, red_nxt;
  logic [7:0] green_r, green_nxt;
  logic [7:0] mask_r, mask_nxt;
  logic [7:0] blink_r, blink_nxt;
  logic [7:0] cfg_r, cfg_nxt;
  logic [7:0] diag_r, diag_nxt;
  logic [7:0] dout_r, dout_nxt;
  logic oe_r, oe_nxt;
  logic pal_we, ovl_we;
  logic [23:0] wr_word;
  logic [23:0] pal_rd, ovl_rd;
  logic [7:0] ctl_rd;
  logic [7:0] comp_rd;
  logic [23:0] ent_rd;

  assign pal_rd = pal_mem[ptr_r[$clog2(PAL_DEPTH)-1:0]];
  assign ovl_rd = ovl_mem[ptr_r[$clog2(OVL_DEPTH)-1:0]];

  always_comb begin
    unique case (ptr_r)
      IDX_READ_MASK: ctl_rd = mask_r;
      IDX_BLINK_MASK: ctl_rd = blink_r;
      IDX_CONFIG: ctl_rd = cfg_r;
      IDX_DIAG: ctl_rd = diag_r;
      default: ctl_rd = 8'h00;
    endcase
    ent_rd = (sel_s == SEL_OVERLAY) ? ovl_rd : pal_rd;
    unique case (comp_r)
      COMP_RED: comp_rd = ent_rd[23:16];
      COMP_GREEN: comp_rd = ent_rd[15:8];
      default: comp_rd = ent_rd[7:0];
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    rd_nxt = rd_r;
    sel_nxt = sel_r;
    ptr_nxt = ptr_r;
    comp_nxt = comp_r;
    red_nxt = red_r;
    green_nxt = green_r;
    mask_nxt = mask_r;
    blink_nxt = blink_r;
    cfg_nxt = cfg_r;
    diag_nxt = diag_r;
    dout_nxt = dout_r;
    oe_nxt = oe_r;
    pal_we = 1'b0;
    ovl_we = 1'b0;
    wr_word = {red_r, green_r, din_s};
    unique case (state_r)
      PDH_IDLE: begin
        if (!ce_n_s) begin
          // Capture at falling strobe edge
          state_nxt = PDH_ACTIVE;
          rd_nxt = rd_s;
          sel_nxt = sel_s;
          if (rd_s) begin
            oe_nxt = 1'b1;
            unique case (sel_s)
              SEL_POINTER: dout_nxt = ptr_r;
              SEL_CONTROL: dout_nxt = ctl_rd;
              default: dout_nxt = comp_rd;
            endcase
          end
        end
      end
      PDH_ACTIVE: begin
        if (ce_n_s) begin
          // Rising strobe edge completes the access
          state_nxt = PDH_IDLE;
          oe_nxt = 1'b0;
          if (!rd_r) begin
            unique case (sel_r)
              SEL_POINTER: begin
                ptr_nxt = din_s;
                comp_nxt = COMP_RED;
              end
              SEL_CONTROL: begin
                if (ptr_r == IDX_READ_MASK) mask_nxt = din_s;
                if (ptr_r == IDX_BLINK_MASK) blink_nxt = din_s;
                if (ptr_r == IDX_CONFIG) cfg_nxt = din_s;
                if (ptr_r == IDX_DIAG) diag_nxt = din_s;
              end
              default: begin
                // Components held until blue so the entry updates whole
                if (comp_r == COMP_RED) red_nxt = din_s;
                if (comp_r == COMP_GREEN) green_nxt = din_s;
                if (comp_r == COMP_BLUE) begin
                  pal_we = (sel_r == SEL_PALETTE);
                  ovl_we = (sel_r == SEL_OVERLAY);
                end
              end
            endcase
          end
          if (sel_r[0]) begin
            if (comp_r == COMP_BLUE) begin
              comp_nxt = COMP_RED;
              ptr_nxt = ptr_r + 8'h01;
            end else begin
              comp_nxt = comp_r + 2'h1;
            end
          end
        end
      end
      default: state_nxt = PDH_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state_r <= PDH_IDLE;
      rd_r <= 1'b0;
      sel_r <= SEL_POINTER;
      ptr_r <= RST_POINTER;
      comp_r <= COMP_RED;
      red_r <= 8'h00;
      green_r <= 8'h00;
      mask_r <= RST_READ_MASK;
      blink_r <= RST_BLINK_MASK;
      cfg_r <= RST_CONFIG;
      diag_r <= RST_DIAG;
      dout_r <= 8'h00;
      oe_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rd_r <= rd_nxt;
      sel_r <= sel_nxt;
      ptr_r <= ptr_nxt;
      comp_r <= comp_nxt;
      red_r <= red_nxt;
      green_r <= green_nxt;
      mask_r <= mask_nxt;
      blink_r <= blink_nxt;
      cfg_r <= cfg_nxt;
      diag_r <= diag_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
    end
  end

  // No reset on palette RAM; host loads it after power-up
  always_ff @(posedge CLK_I) begin
    if (pal_we) begin
      pal_mem[ptr_r[$clog2(PAL_DEPTH)-1:0]] <= wr_word;
    end
    if (ovl_we) begin
      ovl_mem[ptr_r[$clog2(OVL_DEPTH)-1:0]] <= wr_word;
    end
  end

  assign DATA_O = dout_r;
  assign DATA_OE_O = oe_r;
  assign READ_MASK_O = mask_r;
  assign BLINK_MASK_O = blink_r;
  assign CONFIG_O = cfg_r;
  assign DIAG_O = diag_r;
  assign POINTER_O = ptr_r;
endmodule
`default_nettype wire

// >>> verification/pdh_assertions.sv
// Purpose: Port checks for the host port
// Assumes: Host strobe phases of 5+ clocks
// Notes: Attached by bind below
`timescale 1ns/1ps
`default_nettype none
module pdh_assertions
  import pdh_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_N_I,
  input wire logic RD_WR_N_I,
  input wire logic [7:0] DATA_I,
  input wire logic DATA_OE_O,
  input wire logic [7:0] READ_MASK_O,
  input wire logic [7:0] BLINK_MASK_O,
  input wire logic [7:0] CONFIG_O,
  input wire logic [7:0] DIAG_O,
  input wire logic [7:0] POINTER_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  a_read_drive: assert property ($fell(CE_N_I) && RD_WR_N_I |-> ##[2:4] DATA_OE_O) else $error("no drive");
  a_write_quiet: assert property ($fell(CE_N_I) && !RD_WR_N_I |-> !DATA_OE_O [*6]) else $error("drive");
  a_oe_release: assert property ($rose(CE_N_I) |-> ##[2:4] !DATA_OE_O) else $error("no release");
  a_cfg_write: assert property ($changed(CONFIG_O) |-> POINTER_O == IDX_CONFIG
    && CONFIG_O == $past(DATA_I, 2)) else $error("config");
  a_mask_index: assert property ($changed(READ_MASK_O) |-> POINTER_O == IDX_READ_MASK) else $error("mask");
  a_blink_index: assert property ($changed(BLINK_MASK_O) |-> POINTER_O == IDX_BLINK_MASK) else $error("blink");
  a_diag_index: assert property ($changed(DIAG_O) |-> POINTER_O == IDX_DIAG) else $error("diag");
  a_idle_hold: assert property (CE_N_I [*8] |=> $stable(POINTER_O) && !DATA_OE_O) else $error("idle");
  c_read: cover property ($rose(DATA_OE_O));
  c_cfg: cover property ($changed(CONFIG_O));
  c_wrap: cover property ($past(POINTER_O) == 8'hff && POINTER_O == 8'h00);
endmodule
bind pdh_host_port pdh_assertions chk_u (
  .CLK_I(CLK_I),
  .RST_N_I(RST_N_I),
  .CE_N_I(CE_N_I),
  .RD_WR_N_I(RD_WR_N_I),
  .DATA_I(DATA_I),
  .DATA_OE_O(DATA_OE_O),
  .READ_MASK_O(READ_MASK_O),
  .BLINK_MASK_O(BLINK_MASK_O),
  .CONFIG_O(CONFIG_O),
  .DIAG_O(DIAG_O),
  .POINTER_O(POINTER_O)
);
`default_nettype wire

// >>> verification/pdh_host_model.sv
// Purpose: Host model for the strobed port
// Assumes: One access at a time
// Notes: Bus data is inverted at each strobe fall and after reads; after a write the idle bus holds the written byte
`timescale 1ns/1ps
`default_nettype none
module pdh_host_model (
  input wire logic clk_i,
  output logic ce_n_o,
  output logic rd_wr_n_o,
  output logic [1:0] sel_o,
  output logic [7:0] data_o
);
  initial begin
    ce_n_o = 1'b1;
    rd_wr_n_o = 1'b1;
    sel_o = 2'h0;
    data_o = 8'h5a;
  end
  // Phases of 5 clocks or more, well over the 3-clock minimum
  task automatic go(input logic [1:0] a, input logic r, input logic [7:0] d, input int slow);
    @(posedge clk_i);
    ce_n_o <= 1'b0;
    rd_wr_n_o <= r;
    sel_o <= a;
    data_o <= ~data_o;
    repeat (5 + slow) @(posedge clk_i);
    ce_n_o <= 1'b1;
    data_o <= r ? ~data_o : d;
    repeat (5 + slow) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Purpose: Bench for the host port
// Assumes: Host model paces every strobe
// Notes: Reads queue their expected data
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pdh_pkg::*;
;
  logic CLK_I = 1'b0;
  logic RST_N_I = 1'b0;
  logic CE_N_I, RD_WR_N_I, DATA_OE_O;
  logic [1:0] sel, s;
  logic [7:0] DATA_I, DATA_O, READ_MASK_O, BLINK_MASK_O, CONFIG_O, DIAG_O, POINTER_O, p;
  logic [7:0] v[6];
  logic [7:0] expq[$];
  logic [16:0] lfsr = 17'h176a8;
  logic [39:0] regs;
  int err_total = 0;
  int n_checks = 0;
  assign regs = {READ_MASK_O, BLINK_MASK_O, CONFIG_O, DIAG_O, POINTER_O};
  pdh_host_model host_u (.clk_i(CLK_I), .ce_n_o(CE_N_I), .rd_wr_n_o(RD_WR_N_I), .sel_o(sel), .data_o(DATA_I));
  pdh_host_port dut_u (
    .CLK_I(CLK_I),
    .RST_N_I(RST_N_I),
    .CE_N_I(CE_N_I),
    .RD_WR_N_I(RD_WR_N_I),
    .SELECT_HIGH_I(sel[1]),
    .SELECT_LOW_I(sel[0]),
    .DATA_I(DATA_I),
    .DATA_O(DATA_O),
    .DATA_OE_O(DATA_OE_O),
    .READ_MASK_O(READ_MASK_O),
    .BLINK_MASK_O(BLINK_MASK_O),
    .CONFIG_O(CONFIG_O),
    .DIAG_O(DIAG_O),
    .POINTER_O(POINTER_O)
  );
  task automatic cmp(input logic [39:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Read data has its own compare so a bad byte is reported at its width
  task automatic cmp_data(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t read %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    expq.push_back(e);
    host_u.go(a, 1'b1, 8'h00, 0);
  endtask
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
    return lfsr[7:0];
  endfunction
  task automatic end_of_test();
    $display("Checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    forever #12.5 CLK_I = ~CLK_I;
  end
  always @(posedge CLK_I) begin
    if ($rose(DATA_OE_O))
      cmp_data(DATA_O, expq.size() > 0 ? expq.pop_front() : 8'hxx);
  end
  initial begin
    repeat (8) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    cmp(regs, {RST_READ_MASK, RST_BLINK_MASK, RST_CONFIG, RST_DIAG, RST_POINTER});
    // Index 08 is unmapped: write ignored, reads 00
    for (int i = 4; i < 9; i++) begin
      v[i - 4] = rnd();
      host_u.go(SEL_POINTER, 1'b0, 8'(i), 0);
      host_u.go(SEL_CONTROL, 1'b0, v[i - 4], i % 2 * 3);
      rd(SEL_CONTROL, i < 8 ? v[i - 4] : 8'h00);
    end
    cmp(regs, {v[0], v[1], v[2], v[3], 8'h08});
    rd(SEL_POINTER, 8'h08);
    // Palette starts at fe so the pointer wraps
    for (int m = 0; m < 2; m++) begin
      s = m ? SEL_OVERLAY : SEL_PALETTE;
      p = m ? 8'h00 : 8'hfe;
      host_u.go(SEL_POINTER, 1'b0, p, 0);
      for (int k = 0; k < 6 - 3 * m; k++) begin
        v[k] = rnd();
        host_u.go(s, 1'b0, v[k], k % 2);
      end
      cmp(POINTER_O, 8'(p + 8'h02 - 8'(m)));
      host_u.go(SEL_POINTER, 1'b0, p, 0);
      for (int k = 0; k < 6 - 3 * m; k++)
        rd(s, v[k]);
      cmp(POINTER_O, 8'(p + 8'h02 - 8'(m)));
    end
    // Mid-run reset must bring back the power-up state
    RST_N_I <= 1'b0;
    repeat (4) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    cmp(regs, {RST_READ_MASK, RST_BLINK_MASK, RST_CONFIG, RST_DIAG, RST_POINTER});
    host_u.go(SEL_POINTER, 1'b0, IDX_CONFIG, 0);
    rd(SEL_CONTROL, RST_CONFIG);
    cmp(40'(expq.size()), 40'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
